// ---- rtl/lbw_pkg.sv ----
// Constants shared by the log and block write command interpreter.
package lbw_pkg;
  // Word offsets of the task-file and control registers on AXI4-Lite.
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_FEATURE = 8'h04;
  localparam logic [7:0] OFF_ERROR = 8'h08;
  localparam logic [7:0] OFF_SCOUNT = 8'h0C;
  localparam logic [7:0] OFF_SNUM = 8'h10;
  localparam logic [7:0] OFF_CYL_LO = 8'h14;
  localparam logic [7:0] OFF_CYL_HI = 8'h18;
  localparam logic [7:0] OFF_UNIT_HEAD = 8'h1C;
  localparam logic [7:0] OFF_COMMAND = 8'h20;
  localparam logic [7:0] OFF_STATE = 8'h24;
  localparam logic [7:0] OFF_MULTI = 8'h28;
  localparam logic [7:0] OFF_LOG_DIR = 8'h2C;
  // Command opcodes.
  localparam logic [7:0] OP_LOG_WRITE = 8'h3F;
  localparam logic [7:0] OP_BLOCK_WRITE = 8'hC5;
  // Error register bit positions.
  localparam int ERR_ABORT_BIT = 2;
  localparam int ERR_IDNF_BIT = 4;
  // Status register bit positions.
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DF_BIT = 5;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  // Unit/head register fields.
  localparam int UH_LBA_BIT = 6;
  // Log directory write fields.
  localparam int LD_SIZE_W = 16;
  localparam int LD_WRITABLE_BIT = 16;
  localparam int LD_ENABLE_BIT = 17;
  localparam int LD_INDEX_LSB = 24;
  // Sector geometry.
  localparam int SECTOR_BYTES = 512;
  localparam int WORDS_PER_SECTOR = SECTOR_BYTES / 2;
  localparam logic [7:0] LAST_WORD = 8'(WORDS_PER_SECTOR - 1);
  localparam logic [16:0] ZERO_COUNT_SECTORS = 17'h00100;
  localparam logic [7:0] LOG_BLOCK_SECTORS = 8'h01;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lbw_pkg

// ---- rtl/lbw_cmd.sv ----
// Log write and block write command interpreter with an AXI4-Lite task file.
// Functional notes
// - opcode 3Fh starts the log write
// - accept 512-byte sectors into chosen log
// - log write interrupts once per sector block
// - abort when count exceeds directory log size
// - log start sector from cylinder low bytes
// - log address from sector number; read-only aborts
// - abort on disabled log or invalid values
// - opcode C5h accepts sectors for the media
// - block write interrupts once per multiple block
// - data moves one 16-bit word per access
// - zero sector count means 256 sectors
// - LBA mode builds 28-bit address
// - CHS mode uses sector, cylinder, head
// - block write residual count left in sector count
// - last transferred block write address left in registers
module lbw_cmd #(
  parameter int LOG_COUNT = 16,
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEAD_COUNT = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic media_fault,
  output logic host_intrq,
  output logic [15:0] media_word,
  output logic media_valid,
  output logic media_to_log,
  output logic [27:0] media_addr
);
  localparam int LIW = $clog2(LOG_COUNT);

  typedef enum logic [1:0] {
    LBW_IDLE = 2'b01,
    LBW_XFER = 2'b10
  } lbw_phase_t;

  typedef struct packed {
    lbw_phase_t phase;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] feature_byte;
    logic [7:0] error_flags;
    logic [7:0] sc_cur;
    logic [7:0] sc_prev;
    logic [7:0] sector_number;
    logic [7:0] cl_cur;
    logic [7:0] cl_prev;
    logic [7:0] cylinder_high_byte;
    logic [7:0] unit_and_head_select;
    logic transfer_request;
    logic err_status;
    logic intrq;
    logic is_log;
    logic lba_mode;
    logic [16:0] rem;
    logic [7:0] blk_left;
    logic [7:0] word_cnt;
    logic [27:0] addr;
    logic [7:0] log_id;
    logic [15:0] log_sec;
    logic [7:0] multi;
    logic [LOG_COUNT-1:0][15:0] log_size;
    logic [LOG_COUNT-1:0] log_writable;
    logic [LOG_COUNT-1:0] log_enabled;
    logic [15:0] media_word;
    logic media_valid;
    logic [27:0] media_addr;
  } lbw_state_t;

  lbw_state_t s_reg;
  lbw_state_t s_next;

  logic wr_fire;
  logic cmd_fire;
  logic data_fire;
  logic sec_done;
  logic [15:0] log_count;
  logic [15:0] log_start;
  logic [16:0] log_end;
  logic log_bad;
  logic [16:0] rem_new;
  logic [27:0] addr_inc;
  logic [27:0] start_addr;

  // Log command fields and checks, decoded straight from the task file.
  always_comb begin
    log_count = {s_reg.sc_prev, s_reg.sc_cur};
    log_start = {s_reg.cl_prev, s_reg.cl_cur};
    log_end = {1'b0, log_start} + {1'b0, log_count};
    // Index zero is the directory itself and is never writable.
    log_bad = s_reg.sector_number >= 8'(LOG_COUNT) || s_reg.sector_number == 8'h00
              || !s_reg.log_writable[s_reg.sector_number[LIW-1:0]]
              || !s_reg.log_enabled[s_reg.sector_number[LIW-1:0]]
              || log_end > {1'b0, s_reg.log_size[s_reg.sector_number[LIW-1:0]]}
              || log_count == 16'h0000;
  end
  // Start address: both modes pack head, cylinder and sector the same way.
  assign start_addr = {s_reg.unit_and_head_select[3:0], s_reg.cylinder_high_byte,
                       s_reg.cl_cur, s_reg.sector_number};

  // Next address after a finished sector, by LBA or by CHS geometry.
  always_comb begin
    addr_inc = s_reg.addr;
    if (s_reg.lba_mode) addr_inc = s_reg.addr + 28'h0000001;
    else if (s_reg.addr[7:0] >= 8'(SECTORS_PER_TRACK)) begin
      addr_inc[7:0] = 8'h01;
      if (s_reg.addr[27:24] >= 4'(HEAD_COUNT - 1)) begin
        addr_inc[27:24] = 4'h0;
        addr_inc[23:8] = s_reg.addr[23:8] + 16'h0001;
      end else begin
        addr_inc[27:24] = s_reg.addr[27:24] + 4'h1;
      end
    end else begin
      addr_inc[7:0] = s_reg.addr[7:0] + 8'h01;
    end
  end

  assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
  assign cmd_fire = wr_fire && s_reg.aw_addr == lbw_pkg::OFF_COMMAND && s_reg.w_strb[0]
                    && s_reg.phase == LBW_IDLE;
  assign data_fire = wr_fire && s_reg.aw_addr == lbw_pkg::OFF_DATA
                     && s_reg.w_strb[1:0] == 2'h3 && s_reg.phase == LBW_XFER;
  assign sec_done = data_fire && s_reg.word_cnt == lbw_pkg::LAST_WORD && !media_fault;
  assign rem_new = s_reg.rem - 17'h00001;
  // Whole next state: bus handshakes first, then register and command effects.
  always_comb begin
    s_next = s_reg;
    s_next.media_valid = 1'b0;
    // Write address and data are caught independently, in either order.
    if (s_reg.awready && s_axi_awvalid) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_reg.wready && s_axi_wvalid) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
    if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
    // Reads answer one cycle after the address is taken; status read clears intrq.
    if (s_reg.arready && s_axi_arvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = lbw_pkg::RESP_OKAY;
      s_next.rdata = 32'h00000000;
      unique case (s_axi_araddr[7:0])
        lbw_pkg::OFF_DATA, lbw_pkg::OFF_FEATURE, lbw_pkg::OFF_COMMAND,
        lbw_pkg::OFF_LOG_DIR: s_next.rdata = 32'h00000000;
        lbw_pkg::OFF_ERROR: s_next.rdata[7:0] = s_reg.error_flags;
        lbw_pkg::OFF_SCOUNT: s_next.rdata[7:0] = s_reg.sc_cur;
        lbw_pkg::OFF_SNUM: s_next.rdata[7:0] = s_reg.sector_number;
        lbw_pkg::OFF_CYL_LO: s_next.rdata[7:0] = s_reg.cl_cur;
        lbw_pkg::OFF_CYL_HI: s_next.rdata[7:0] = s_reg.cylinder_high_byte;
        lbw_pkg::OFF_UNIT_HEAD: s_next.rdata[7:0] = s_reg.unit_and_head_select;
        lbw_pkg::OFF_MULTI: s_next.rdata[7:0] = s_reg.multi;
        lbw_pkg::OFF_STATE: begin
          s_next.rdata[lbw_pkg::ST_RDY_BIT] = 1'b1;
          s_next.rdata[lbw_pkg::ST_DSC_BIT] = 1'b1;
          s_next.rdata[lbw_pkg::ST_DRQ_BIT] = s_reg.transfer_request;
          s_next.rdata[lbw_pkg::ST_ERR_BIT] = s_reg.err_status;
          s_next.intrq = 1'b0;
        end
        default: s_next.rresp = lbw_pkg::RESP_SLVERR;
      endcase
    end
    // A write completes once both halves are held; the response follows.
    if (wr_fire) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = lbw_pkg::RESP_OKAY;
      unique case (s_reg.aw_addr)
        lbw_pkg::OFF_DATA, lbw_pkg::OFF_COMMAND, lbw_pkg::OFF_ERROR,
        lbw_pkg::OFF_STATE: ;
        lbw_pkg::OFF_FEATURE, lbw_pkg::OFF_SCOUNT, lbw_pkg::OFF_SNUM,
        lbw_pkg::OFF_CYL_LO, lbw_pkg::OFF_CYL_HI, lbw_pkg::OFF_UNIT_HEAD: begin
          // Host writes to the task file are ignored while a transfer is in progress.
          if (s_reg.phase == LBW_IDLE && s_reg.w_strb[0]) begin
            unique case (s_reg.aw_addr)
              lbw_pkg::OFF_FEATURE: s_next.feature_byte = s_reg.w_data[7:0];
              lbw_pkg::OFF_SCOUNT: begin
                s_next.sc_prev = s_reg.sc_cur;
                s_next.sc_cur = s_reg.w_data[7:0];
              end
              lbw_pkg::OFF_SNUM: s_next.sector_number = s_reg.w_data[7:0];
              lbw_pkg::OFF_CYL_LO: begin
                s_next.cl_prev = s_reg.cl_cur;
                s_next.cl_cur = s_reg.w_data[7:0];
              end
              lbw_pkg::OFF_CYL_HI: s_next.cylinder_high_byte = s_reg.w_data[7:0];
              default: s_next.unit_and_head_select = s_reg.w_data[7:0];
            endcase
          end
        end
        lbw_pkg::OFF_MULTI: begin
          if (s_reg.phase == LBW_IDLE && s_reg.w_strb[0])
            s_next.multi = s_reg.w_data[7:0];
        end
        lbw_pkg::OFF_LOG_DIR: begin
          if (s_reg.phase == LBW_IDLE && s_reg.w_strb == 4'hF) begin
            s_next.log_size[s_reg.w_data[lbw_pkg::LD_INDEX_LSB +: LIW]] =
              s_reg.w_data[lbw_pkg::LD_SIZE_W-1:0];
            s_next.log_writable[s_reg.w_data[lbw_pkg::LD_INDEX_LSB +: LIW]] =
              s_reg.w_data[lbw_pkg::LD_WRITABLE_BIT];
            s_next.log_enabled[s_reg.w_data[lbw_pkg::LD_INDEX_LSB +: LIW]] =
              s_reg.w_data[lbw_pkg::LD_ENABLE_BIT];
          end
        end
        default: s_next.bresp = lbw_pkg::RESP_SLVERR;
      endcase
    end
    // Command start: checks run in the same cycle, so an abort is immediate.
    if (cmd_fire) begin
      s_next.error_flags = 8'h00;
      s_next.err_status = 1'b0;
      s_next.word_cnt = 8'h00;
      s_next.is_log = 1'b0;
      if (s_reg.w_data[7:0] == lbw_pkg::OP_LOG_WRITE && !log_bad) begin
        s_next.is_log = 1'b1;
        s_next.phase = LBW_XFER;
        s_next.transfer_request = 1'b1;
        s_next.rem = {1'b0, log_count};
        s_next.log_id = s_reg.sector_number;
        s_next.log_sec = log_start;
        s_next.blk_left = lbw_pkg::LOG_BLOCK_SECTORS;
      end else if (s_reg.w_data[7:0] == lbw_pkg::OP_BLOCK_WRITE && s_reg.multi != 8'h00) begin
        s_next.phase = LBW_XFER;
        s_next.transfer_request = 1'b1;
        s_next.lba_mode = s_reg.unit_and_head_select[lbw_pkg::UH_LBA_BIT];
        s_next.addr = start_addr;
        s_next.blk_left = s_reg.multi;
        // A zero count asks for the largest transfer.
        s_next.rem = (s_reg.sc_cur == 8'h00) ? lbw_pkg::ZERO_COUNT_SECTORS
                                              : {9'h000, s_reg.sc_cur};
      end else begin
        // Bad log parameters, a missing block size or an unknown opcode.
        s_next.error_flags[lbw_pkg::ERR_ABORT_BIT] = 1'b1;
        s_next.err_status = 1'b1;
        s_next.transfer_request = 1'b0;
        s_next.intrq = 1'b1;
      end
    end
    // A media fault ends the block write early and leaves the residual count.
    if (s_reg.phase == LBW_XFER && media_fault) begin
      s_next.phase = LBW_IDLE;
      s_next.transfer_request = 1'b0;
      s_next.error_flags[lbw_pkg::ERR_IDNF_BIT] = 1'b1;
      s_next.err_status = 1'b1;
      s_next.intrq = 1'b1;
      if (!s_reg.is_log) s_next.sc_cur = s_reg.rem[7:0];
    end else if (data_fire) begin
      // Each data port write carries one 16-bit word to the media side.
      s_next.media_word = s_reg.w_data[15:0];
      s_next.media_valid = 1'b1;
      s_next.media_addr = s_reg.is_log ? {4'h0, s_reg.log_id, s_reg.log_sec} : s_reg.addr;
      s_next.word_cnt = s_reg.word_cnt + 8'h01;
      if (sec_done) begin
        s_next.word_cnt = 8'h00;
        s_next.rem = rem_new;
        s_next.blk_left = s_reg.blk_left - 8'h01;
        if (s_reg.is_log) s_next.log_sec = s_reg.log_sec + 16'h0001;
        else begin
          // Registers always show the last sector that went through.
          s_next.sc_cur = rem_new[7:0];
          s_next.sector_number = s_reg.addr[7:0];
          s_next.cl_cur = s_reg.addr[15:8];
          s_next.cylinder_high_byte = s_reg.addr[23:16];
          s_next.unit_and_head_select[3:0] = s_reg.addr[27:24];
          s_next.addr = addr_inc;
        end
        // One interrupt per finished block, or at the final sector.
        if (rem_new == 17'h00000 || s_reg.blk_left == 8'h01) begin
          s_next.intrq = 1'b1;
          s_next.blk_left = s_reg.is_log ? lbw_pkg::LOG_BLOCK_SECTORS : s_reg.multi;
        end
        if (rem_new == 17'h00000) begin
          s_next.phase = LBW_IDLE;
          s_next.transfer_request = 1'b0;
        end
      end
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end
  // State register with synchronous reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.phase <= LBW_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign host_intrq = s_reg.intrq;
  assign media_word = s_reg.media_word;
  assign media_valid = s_reg.media_valid;
  assign media_to_log = s_reg.is_log;
  assign media_addr = s_reg.media_addr;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // An abort leaves error, completion and no pending transfer together.
  property p_abort_flags;
    $rose(s_reg.error_flags[lbw_pkg::ERR_ABORT_BIT]) |->
      s_reg.err_status && !s_reg.transfer_request && s_reg.intrq;
  endproperty
  a_abort_flags: assert property (p_abort_flags) else $error("abort flags wrong");

  // A finished log sector raises the interrupt on the next edge.
  property p_log_irq;
    sec_done && s_reg.is_log |=> s_reg.intrq;
  endproperty
  a_log_irq: assert property (p_log_irq) else $error("log sector without interrupt");

  // Mid-block sectors of the block write raise no interrupt.
  property p_block_no_irq;
    sec_done && !s_reg.is_log && s_reg.blk_left != 8'h01 && s_reg.rem != 17'h00001
      |=> !$rose(s_reg.intrq);
  endproperty
  a_block_no_irq: assert property (p_block_no_irq) else $error("early interrupt");

  // A zero sector count becomes 256 sectors.
  property p_zero_count;
    cmd_fire && s_reg.w_data[7:0] == lbw_pkg::OP_BLOCK_WRITE && s_reg.multi != 8'h00
      && s_reg.sc_cur == 8'h00 |=> s_reg.rem == lbw_pkg::ZERO_COUNT_SECTORS;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count not 256");

  // A clean end of a block write leaves no residual count.
  property p_residual;
    $fell(s_reg.transfer_request) && !s_reg.is_log && !s_reg.err_status |->
      s_reg.sc_cur == 8'h00;
  endproperty
  a_residual: assert property (p_residual) else $error("residual count nonzero");

  // An oversized log request is aborted on the next edge.
  property p_log_size;
    cmd_fire && s_reg.w_data[7:0] == lbw_pkg::OP_LOG_WRITE && log_end >
      {1'b0, s_reg.log_size[s_reg.sector_number[LIW-1:0]]} |=>
      s_reg.error_flags[lbw_pkg::ERR_ABORT_BIT] && !s_reg.transfer_request;
  endproperty
  a_log_size: assert property (p_log_size) else $error("oversized log not aborted");

  // The media word is the low half of the data port write before it.
  property p_word;
    data_fire && !media_fault |=> media_valid && media_word == $past(s_reg.w_data[15:0]);
  endproperty
  a_word: assert property (p_word) else $error("data word lost");

  // LBA mode takes the start address from the four address registers.
  property p_lba_start;
    cmd_fire && s_reg.w_data[7:0] == lbw_pkg::OP_BLOCK_WRITE && s_reg.multi != 8'h00
      |=> s_reg.addr == $past(start_addr) && s_reg.transfer_request;
  endproperty
  a_lba_start: assert property (p_lba_start) else $error("bad start address");
endmodule : lbw_cmd

// ---- tb/lbw_host_model.sv ----
// Host controller model: an AXI4-Lite master that reaches the task-file registers.
module lbw_host_model (
  input wire logic core_clk,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic timed_out
);
  // Every master line starts at a known idle value.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, timed_out} = '0;
  end

  // One write; each channel drops on its own handshake, bready stays up until bvalid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    resp = 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 100) timed_out <= 1'b1;
  endtask : wr

  // One read; the data is taken at the edge where rvalid and rready meet.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    d = 32'hFFFFFFFF;
    resp = 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 100) timed_out <= 1'b1;
  endtask : rd

  // Sector data goes one 16-bit word per access, so a sector costs 256 bus writes.
  task automatic send_words(input int count);
    logic [1:0] r;
    for (int i = 0; i < count; i++) begin
      wr(8'h00, {16'h0000, 16'(i) ^ 16'h5A3C}, 4'h3, r);
    end
    // One spare edge lets the bench's word counter take the last pulse.
    @(posedge core_clk);
  endtask : send_words
endmodule : lbw_host_model

// ---- tb/tb_lbw_cmd.sv ----
// Self-checking testbench of the log and block write command interpreter.
module tb_lbw_cmd;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} lbw_row_t;
  logic core_clk, rst_n, media_fault, host_intrq, media_valid, media_to_log, host_timed_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] media_word, first_word;
  logic [27:0] media_addr, first_addr;
  int err_count, n_compared, n_words, mark;
  lbw_row_t rows [5];
  logic [31:0] bad_dir [3];
  logic [7:0] bad_cnt [3];

  lbw_cmd lbw_cmd_inst (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .media_fault(media_fault), .host_intrq(host_intrq),
    .media_word(media_word), .media_valid(media_valid), .media_to_log(media_to_log),
    .media_addr(media_addr));
  lbw_host_model lbw_host_model_inst (.core_clk(core_clk), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timed_out(host_timed_out));

  // The clock runs at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Counts media words and keeps the first one after the mark, for address checks.
  always @(posedge core_clk) begin
    if (media_valid === 1'b1) begin
      if (n_words == mark) begin
        first_word <= media_word;
        first_addr <= media_addr;
      end
      n_words <= n_words + 1;
    end
  end

  // A bus wait that ran out ends the run as a failure.
  always @(posedge core_clk) begin
    if (host_timed_out === 1'b1) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic [7:0] a, input logic [7:0] v);
    lbw_host_model_inst.wr(a, {24'h000000, v}, 4'h1, rsp);
  endtask : wb

  task automatic rd(input logic [7:0] a);
    lbw_host_model_inst.rd(a, d, rsp);
  endtask : rd

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Main sequence: reset, register rows, then the command scenarios.
  initial begin
    rst_n = 1'b0;
    media_fault = 1'b0;
    {err_count, n_compared, n_words, mark} = '0;
    rows = '{'{8'h10, 32'h5A5A5AA5, 32'hA5, 2'h0}, '{8'h18, 32'h3C, 32'h3C, 2'h0},
      '{8'h1C, 32'hE1, 32'hE1, 2'h0}, '{8'h28, 32'h02, 32'h02, 2'h0},
      '{8'h30, 32'h77, 32'h00, 2'h2}};
    bad_dir = '{32'h01030004, 32'h02020004, 32'h03010004};
    bad_cnt = '{8'h05, 8'h01, 8'h01};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h24);
    chk("status after reset", d, 32'h50);
    chk("intrq after reset", 32'(host_intrq), 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      lbw_host_model_inst.wr(rows[i].a, rows[i].d, 4'h1, rsp);
      chk("write resp", 32'(rsp), 32'(rows[i].r));
      rd(rows[i].a);
      chk("read back", d, rows[i].q);
      chk("read resp", 32'(rsp), 32'(rows[i].r));
    end
    $display("test register rows done");
    // Log 1 holds 4 sectors; one sector is written at log sector 2.
    lbw_host_model_inst.wr(8'h2C, 32'h01030004, 4'hF, rsp);
    wb(8'h0C, 8'h00);
    wb(8'h0C, 8'h01);
    wb(8'h14, 8'h00);
    wb(8'h14, 8'h02);
    wb(8'h10, 8'h01);
    mark = n_words;
    wb(8'h20, lbw_pkg::OP_LOG_WRITE);
    rd(8'h24);
    chk("log status busy", d, 32'h58);
    lbw_host_model_inst.send_words(256);
    chk("log words", 32'(n_words - mark), 32'd256);
    chk("log first word", 32'(first_word), 32'h5A3C);
    chk("log address", 32'(first_addr), 32'h0010002);
    chk("log target", 32'(media_to_log), 32'h1);
    chk("log intrq", 32'(host_intrq), 32'h1);
    rd(8'h24);
    chk("log status done", d, 32'h50);
    chk("intrq cleared", 32'(host_intrq), 32'h0);
    $display("test log write done");
    // Count past the log size, a read-only log and a disabled log all abort.
    foreach (bad_dir[i]) begin
      lbw_host_model_inst.wr(8'h2C, bad_dir[i], 4'hF, rsp);
      wb(8'h0C, 8'h00);
      wb(8'h0C, bad_cnt[i]);
      wb(8'h14, 8'h00);
      wb(8'h14, 8'h00);
      wb(8'h10, bad_dir[i][31:24]);
      wb(8'h20, lbw_pkg::OP_LOG_WRITE);
      rd(8'h08);
      chk("abort error", d, 32'h04);
      chk("abort intrq", 32'(host_intrq), 32'h1);
      rd(8'h24);
      chk("abort status", d, 32'h51);
    end
    $display("test log aborts done");
    // Block write, LBA form, 3 sectors in blocks of 2.
    wb(8'h28, 8'h02);
    wb(8'h1C, 8'hE1);
    wb(8'h10, 8'h78);
    wb(8'h14, 8'h56);
    wb(8'h18, 8'h34);
    wb(8'h0C, 8'h03);
    mark = n_words;
    wb(8'h20, lbw_pkg::OP_BLOCK_WRITE);
    lbw_host_model_inst.send_words(256);
    chk("no intrq mid block", 32'(host_intrq), 32'h0);
    lbw_host_model_inst.send_words(256);
    chk("intrq first block", 32'(host_intrq), 32'h1);
    rd(8'h24);
    lbw_host_model_inst.send_words(256);
    chk("intrq last block", 32'(host_intrq), 32'h1);
    chk("block words", 32'(n_words - mark), 32'd768);
    chk("lba address", 32'(first_addr), 32'h1345678);
    chk("media target", 32'(media_to_log), 32'h0);
    rd(8'h0C);
    chk("residual count", d, 32'h00);
    rd(8'h10);
    chk("last lba low", d, 32'h7A);
    rd(8'h18);
    chk("last lba high", d, 32'h34);
    rd(8'h24);
    $display("test block lba done");
    // CHS form, one sector at head 2, cylinder 0102h, sector 5.
    wb(8'h1C, 8'hA2);
    wb(8'h10, 8'h05);
    wb(8'h14, 8'h01);
    wb(8'h14, 8'h02);
    wb(8'h18, 8'h01);
    wb(8'h0C, 8'h01);
    mark = n_words;
    wb(8'h20, lbw_pkg::OP_BLOCK_WRITE);
    lbw_host_model_inst.send_words(256);
    chk("chs address", 32'(first_addr), 32'h2010205);
    chk("chs final intrq", 32'(host_intrq), 32'h1);
    rd(8'h10);
    chk("chs last sector", d, 32'h05);
    rd(8'h24);
    $display("test block chs done");
    // Zero count means 256 sectors; a fault after one leaves 255 pending.
    wb(8'h1C, 8'hE0);
    wb(8'h0C, 8'h00);
    wb(8'h20, lbw_pkg::OP_BLOCK_WRITE);
    lbw_host_model_inst.send_words(256);
    media_fault <= 1'b1;
    repeat (2) @(posedge core_clk);
    media_fault <= 1'b0;
    rd(8'h0C);
    chk("residual after fault", d, 32'hFF);
    rd(8'h08);
    chk("fault error", d, 32'h10);
    rd(8'h24);
    chk("fault status", d, 32'h51);
    $display("test fault done");
    // A reset in mid-run must clear the error state and the residual count.
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h24);
    chk("status after mid reset", d, 32'h50);
    rd(8'h0C);
    chk("count after mid reset", d, 32'h00);
    $display("test mid reset done");
    final_report();
  end
endmodule : tb_lbw_cmd
